// ---- rtl/rtcu_pkg.sv ----
// shared constants and types for the clock register update control
package rtcu_pkg;
  localparam int ADDR_W = 19; // byte address width
  localparam int DATA_W = 8; // data bus width
  localparam int IDX_W = 3; // clock register index width
  localparam logic [ADDR_W-IDX_W-1:0] TOP_PAGE = 16'hffff; // eight top locations
  // register indices within the top eight locations
  localparam logic [IDX_W-1:0] IDX_CENT = 3'h0;
  localparam logic [IDX_W-1:0] IDX_SEC = 3'h1;
  localparam logic [IDX_W-1:0] IDX_MIN = 3'h2;
  localparam logic [IDX_W-1:0] IDX_HOUR = 3'h3;
  localparam logic [IDX_W-1:0] IDX_DAY = 3'h4;
  localparam logic [IDX_W-1:0] IDX_DATE = 3'h5;
  localparam logic [IDX_W-1:0] IDX_MONTH = 3'h6;
  localparam logic [IDX_W-1:0] IDX_YEAR = 3'h7;
  // flag bit positions
  localparam int BIT_WHOLD = 7; // century register write-hold
  localparam int BIT_RHOLD = 6; // century register read-hold
  localparam int BIT_OSC = 7; // seconds register oscillator halt
  localparam int BIT_FT = 6; // day register frequency test
  localparam int BIT_BF = 7; // day register battery flag
  localparam int CENT_W = 6; // century value width
  localparam int SEC_W = 7; // seconds value width
  localparam int DAY_W = 3; // day-of-week width
  localparam logic BATT_OK = 1'b1; // battery flag always reads good
  // bcd limits
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] DAY_MAX = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] CENT_MAX = 8'h39;
  localparam logic [7:0] FEB = 8'h02;
  localparam logic [3:0] BCD_NINE = 4'h9;
  // timing
  localparam longint CLK_HZ = 100000000; // clock rate
  localparam longint FT_HZ = 512; // test toggle rate
  localparam int HALF_CYC = int'(CLK_HZ / (2 * FT_HZ)); // cycles per toggle, rounded down
  localparam int HALVES_PER_SEC = int'(2 * FT_HZ); // toggles per second
  localparam int PRE_W = 24; // prescaler width
  localparam int HALF_W = 10; // toggle counter width
  // clock and calendar value, all bcd
  typedef struct packed {
    logic [7:0] cent;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } rtcu_time_t;
  localparam rtcu_time_t RST_TIME = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h01, 8'h01, 8'h00};
  // pin group sampled from the bus
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } rtcu_pins_t;
endpackage

// ---- rtl/rtcu_sync.sv ----
// two-stage synchroniser for the asynchronous bus pins
`timescale 1ns/1ps
module rtcu_sync (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire rtcu_pkg::rtcu_pins_t pins_i,
  output rtcu_pkg::rtcu_pins_t pins_o
);
  rtcu_pkg::rtcu_pins_t meta; // first stage, read only by second

  // idle bus after reset: deselected
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      meta <= '{1'b1, 1'b1, 1'b1, '0, '0};
      pins_o <= '{1'b1, 1'b1, 1'b1, '0, '0};
    end
    else
    begin
      meta <= pins_i;
      pins_o <= meta;
    end
  end
endmodule // rtcu_sync

// ---- rtl/rtcu_count.sv ----
// internal running clock and calendar counters
`timescale 1ns/1ps
module rtcu_count (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire rtcu_pkg::rtcu_time_t load_val_i,
  output rtcu_pkg::rtcu_time_t cnt_o
);
  // bcd increment of one byte
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == rtcu_pkg::BCD_NINE)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // one step of a field: hold, wrap to first or increment
  function automatic logic [7:0] step(input logic [7:0] v, input logic en,
    input logic wrap, input logic [7:0] first);
    step = !en ? v : (wrap ? first : bcd_inc(v));
  endfunction

  // last date of a month; leap years every four, valid to 2099
  function automatic logic [7:0] last_date(input logic [7:0] mon,
    input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      rtcu_pkg::FEB: last_date = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
  endfunction

  // one second forward with carries up to the century
  function automatic rtcu_pkg::rtcu_time_t advance(input rtcu_pkg::rtcu_time_t t);
    logic c_s, c_m, c_h, c_d, c_mo, c_y;
    c_s = t.sec == rtcu_pkg::SEC_MAX;
    c_m = c_s && t.min == rtcu_pkg::MIN_MAX;
    c_h = c_m && t.hour == rtcu_pkg::HOUR_MAX;
    c_d = c_h && t.date == last_date(t.month, t.year);
    c_mo = c_d && t.month == rtcu_pkg::MONTH_MAX;
    c_y = c_mo && t.year == rtcu_pkg::YEAR_MAX;
    advance = t;
    advance.sec = step(t.sec, 1'b1, c_s, rtcu_pkg::BCD_ZERO);
    advance.min = step(t.min, c_s, c_m, rtcu_pkg::BCD_ZERO);
    advance.hour = step(t.hour, c_m, c_h, rtcu_pkg::BCD_ZERO);
    advance.day = step(t.day, c_h, t.day == rtcu_pkg::DAY_MAX, rtcu_pkg::BCD_ONE);
    advance.date = step(t.date, c_h, c_d, rtcu_pkg::BCD_ONE);
    advance.month = step(t.month, c_d, c_mo, rtcu_pkg::BCD_ONE);
    advance.year = step(t.year, c_mo, c_y, rtcu_pkg::BCD_ZERO);
    advance.cent = step(t.cent, c_y, t.cent == rtcu_pkg::CENT_MAX, rtcu_pkg::BCD_ZERO);
  endfunction

  // counters keep running whatever the visible copy does
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      cnt_o <= rtcu_pkg::RST_TIME;
    else if (load_i)
      cnt_o <= load_val_i;
    else if (tick_i)
      cnt_o <= advance(cnt_o);
  end
endmodule // rtcu_count

// ---- rtl/rtcu_top.sv ----
// clock register update control behind the byte-wide memory bus
// How it works
// - read-hold bit freezes visible time copy
// - frozen copy shows time at halt
// - internal counters keep running while frozen
// - visible copy refreshed within second after release
// - write-hold bit halts visible copy updates
// - clearing write-hold with read-hold bit zero loads counters from copy
// - clearing read-hold resumes, loads nothing
// - setting a hold keeps century value
// - clearing write-hold with read-hold bit zero writes century value
// - clearing read-hold keeps century value
// - oscillator-halt bit stops the oscillator
// - frequency test toggles seconds bit 512Hz
// - sustained seconds read shows the toggle
// - clock registers at top eight addresses
// - time values kept in bcd
`timescale 1ns/1ps
module rtcu_top #(
  parameter int HALF_CYCLES = rtcu_pkg::HALF_CYC // cycles per test toggle
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [rtcu_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rtcu_pkg::DATA_W-1:0] dq_i,
  output logic [rtcu_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o
);
  localparam int IW = rtcu_pkg::IDX_W;
  localparam int DW = rtcu_pkg::DATA_W;

  rtcu_pkg::rtcu_pins_t pins; // synchronised pins
  rtcu_pkg::rtcu_time_t cnt; // internal running time
  rtcu_pkg::rtcu_time_t vis; // host-visible copy
  rtcu_pkg::rtcu_time_t load_val; // value for counter load
  rtcu_pkg::rtcu_time_t next_load_val; // computed load value
  logic load; // counter load pulse
  logic next_load; // load wanted this write
  logic w_hold; // write-hold flag
  logic r_hold; // read-hold flag
  logic hold; // either flag
  logic osc_halt; // oscillator stopped
  logic ft_en; // frequency test enabled
  logic ft_phase; // 512Hz square wave
  logic [rtcu_pkg::PRE_W-1:0] pre; // prescaler
  logic [rtcu_pkg::HALF_W-1:0] halves; // toggles within a second
  logic half_tick; // one toggle period elapsed
  logic sec_tick; // one second elapsed
  logic top_hit; // address is a clock register
  logic wr_act; // write strobe active
  logic wr_act_d; // previous cycle
  logic wr_go; // end of write, commit now
  logic [IW-1:0] wr_idx; // latched write index
  logic [DW-1:0] wr_dat; // latched write data
  logic wr_top; // latched decode hit
  logic is_ctrl; // write targets century register
  logic sets_hold; // write sets a hold flag
  logic rd_act; // read mode on a clock register

  // pins cross into the clock domain first
  rtcu_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pins_i({ce_n_i, oe_n_i, we_n_i, addr_i, dq_i}),
    .pins_o(pins)
  );

  // running counters
  rtcu_count u_count (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_i(sec_tick),
    .load_i(load),
    .load_val_i(load_val),
    .cnt_o(cnt)
  );

  // replace one field; century, seconds and day masked to their value width, other fields taken whole
  function automatic rtcu_pkg::rtcu_time_t put(input rtcu_pkg::rtcu_time_t t,
    input logic [IW-1:0] idx, input logic [DW-1:0] d);
    put = t;
    case (idx)
      rtcu_pkg::IDX_CENT: put.cent = {2'b00, d[rtcu_pkg::CENT_W-1:0]};
      rtcu_pkg::IDX_SEC: put.sec = {1'b0, d[rtcu_pkg::SEC_W-1:0]};
      rtcu_pkg::IDX_MIN: put.min = d;
      rtcu_pkg::IDX_HOUR: put.hour = d;
      rtcu_pkg::IDX_DAY: put.day = {5'h00, d[rtcu_pkg::DAY_W-1:0]};
      rtcu_pkg::IDX_DATE: put.date = d;
      rtcu_pkg::IDX_MONTH: put.month = d;
      default: put.year = d;
    endcase
  endfunction

  assign hold = w_hold | r_hold;
  assign top_hit = pins.addr[rtcu_pkg::ADDR_W-1:IW] == rtcu_pkg::TOP_PAGE;
  assign wr_act = !pins.ce_n && !pins.we_n;
  assign rd_act = !pins.ce_n && !pins.oe_n && pins.we_n && top_hit;
  assign wr_go = wr_act_d && !wr_act && wr_top;
  assign is_ctrl = wr_idx == rtcu_pkg::IDX_CENT;
  assign sets_hold = wr_dat[rtcu_pkg::BIT_WHOLD] | wr_dat[rtcu_pkg::BIT_RHOLD];

  // capture address and data while strobe is low; commit on its release
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wr_act_d <= 1'b0;
      wr_idx <= '0;
      wr_dat <= '0;
      wr_top <= 1'b0;
    end
    else
    begin
      wr_act_d <= wr_act;
      if (wr_act) // data valid up to the end of the cycle
      begin
        wr_idx <= pins.addr[IW-1:0];
        wr_dat <= pins.dq;
        wr_top <= top_hit;
      end
    end
  end

  // hold flags in the century register
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      w_hold <= 1'b0;
      r_hold <= 1'b0;
    end
    else if (wr_go && is_ctrl)
    begin
      w_hold <= wr_dat[rtcu_pkg::BIT_WHOLD];
      r_hold <= wr_dat[rtcu_pkg::BIT_RHOLD];
    end
  end

  // oscillator halt and test flags, writable at any time
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      osc_halt <= 1'b0;
      ft_en <= 1'b0;
    end
    else if (wr_go && wr_idx == rtcu_pkg::IDX_SEC)
      osc_halt <= wr_dat[rtcu_pkg::BIT_OSC];
    else if (wr_go && wr_idx == rtcu_pkg::IDX_DAY)
      ft_en <= wr_dat[rtcu_pkg::BIT_FT];
  end

  // decide whether a write reaches the counters
  always_comb
  begin
    next_load = 1'b0;
    next_load_val = cnt;
    if (wr_go && is_ctrl && !sets_hold)
    begin
      if (w_hold) // release from write-hold: copy becomes the time
      begin
        next_load = 1'b1;
        next_load_val = put(vis, wr_idx, wr_dat);
      end
      else if (!r_hold) // plain century write with no hold pending
      begin
        next_load = 1'b1;
        next_load_val = put(cnt, wr_idx, wr_dat);
      end
      // read-hold release alone loads nothing and keeps century
    end
    else if (wr_go && !is_ctrl && !hold) // direct write while running
    begin
      next_load = 1'b1;
      next_load_val = put(cnt, wr_idx, wr_dat);
    end
  end

  // registered load keeps the counter input path short
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      load <= 1'b0;
      load_val <= rtcu_pkg::RST_TIME;
    end
    else
    begin
      load <= next_load;
      load_val <= next_load_val;
    end
  end

  // visible copy follows counters unless a hold is set
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      vis <= rtcu_pkg::RST_TIME;
    else if (hold && wr_go && !is_ctrl)
      vis <= put(vis, wr_idx, wr_dat);
    else if (!hold)
      vis <= cnt; // all fields at once
  end

  // time base; a second is 1024 toggles, a hair short at 100 MHz
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pre <= '0;
      halves <= '0;
      ft_phase <= 1'b0;
      half_tick <= 1'b0;
      sec_tick <= 1'b0;
    end
    else if (osc_halt)
    begin
      half_tick <= 1'b0;
      sec_tick <= 1'b0;
    end
    else
    begin
      half_tick <= !load && pre == rtcu_pkg::PRE_W'(HALF_CYCLES - 1);
      sec_tick <= 1'b0;
      pre <= (load || pre == rtcu_pkg::PRE_W'(HALF_CYCLES - 1)) ? '0 : pre + 1'b1;
      if (half_tick)
      begin
        ft_phase <= !ft_phase;
        if (halves == rtcu_pkg::HALF_W'(rtcu_pkg::HALVES_PER_SEC - 1))
        begin
          halves <= '0;
          sec_tick <= !load;
        end
        else
          halves <= halves + 1'b1;
      end
      if (load) // a new set point starts a whole second
        halves <= '0;
    end
  end

  // read path, refreshed every cycle so the test toggle ripples through
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      dq_o <= '0;
      dq_oe_o <= 1'b0;
    end
    else
    begin
      dq_oe_o <= rd_act;
      case (pins.addr[IW-1:0])
        rtcu_pkg::IDX_CENT: dq_o <= {w_hold, r_hold, vis.cent[rtcu_pkg::CENT_W-1:0]};
        rtcu_pkg::IDX_SEC: dq_o <= {osc_halt, vis.sec[rtcu_pkg::SEC_W-1:1],
          (ft_en && !osc_halt) ? ft_phase : vis.sec[0]};
        rtcu_pkg::IDX_MIN: dq_o <= vis.min;
        rtcu_pkg::IDX_HOUR: dq_o <= vis.hour;
        rtcu_pkg::IDX_DAY: dq_o <= {rtcu_pkg::BATT_OK, ft_en, 3'h0,
          vis.day[rtcu_pkg::DAY_W-1:0]};
        rtcu_pkg::IDX_DATE: dq_o <= vis.date;
        rtcu_pkg::IDX_MONTH: dq_o <= vis.month;
        default: dq_o <= vis.year;
      endcase
    end
  end

  // checks on the logic above
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_ctrl_write;
    wr_go && is_ctrl;
  endsequence

  property p_hold_freeze;
    hold && !wr_go ##1 hold |-> vis == $past(vis);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("copy moved while held");

  property p_snapshot;
    $rose(r_hold) && !$past(w_hold) |-> vis == $past(cnt);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("copy not time at halt");

  property p_runs_held;
    hold && sec_tick && !load |=> cnt.sec != $past(cnt.sec);
  endproperty
  a_runs_held: assert property (p_runs_held) else $error("counters stopped in hold");

  property p_refresh;
    !hold && !$past(hold) && !(wr_go && !is_ctrl) |=> vis == $past(cnt);
  endproperty
  a_refresh: assert property (p_refresh) else $error("copy not refreshed");

  property p_cent_keep;
    s_ctrl_write ##0 sets_hold |=> ##1 cnt.cent == $past(cnt.cent, 2) ||
      $past(sec_tick);
  endproperty
  a_cent_keep: assert property (p_cent_keep) else $error("century changed on hold set");

  property p_cent_load;
    s_ctrl_write ##0 (!sets_hold && w_hold) |=> ##1
      cnt.cent == {2'b00, $past(wr_dat[rtcu_pkg::CENT_W-1:0], 2)};
  endproperty
  a_cent_load: assert property (p_cent_load) else $error("century not loaded");

  property p_r_release;
    s_ctrl_write ##0 (!sets_hold && r_hold && !w_hold) |=> !load ##0 !hold;
  endproperty
  a_r_release: assert property (p_r_release) else $error("read release loaded");

  property p_osc_stop;
    osc_halt ##1 osc_halt |-> !sec_tick && !half_tick;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("time base ran while halted");

  property p_ft_toggle;
    half_tick && !osc_halt |=> ft_phase != $past(ft_phase);
  endproperty
  a_ft_toggle: assert property (p_ft_toggle) else $error("test phase did not toggle");

  property p_float;
    pins.ce_n |=> !dq_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("drove bus while deselected");
endmodule // rtcu_top

// ---- verif/rtcu_host_model.sv ----
// host processor model driving the asynchronous byte-wide clock bus
`timescale 1ns/1ps
module rtcu_host_model (
  input wire logic clock_i,
  input wire logic dq_oe_i, // device drives the data pins
  input wire logic [rtcu_pkg::DATA_W-1:0] dq_i, // resolved data pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [rtcu_pkg::ADDR_W-1:0] addr_o,
  output logic [rtcu_pkg::DATA_W-1:0] dq_o,
  output logic dq_en_o // host drives the data pins
);
  // idle bus from time zero: deselected, data released
  initial
  begin
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    we_n_o = 1'b1;
    addr_o = '0;
    dq_o = '0;
    dq_en_o = 1'b0;
  end
  // byte write; strobes held four cycles so the synchroniser sees them
  task automatic wr(input logic [rtcu_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    ce_n_o <= 1'b0;
    we_n_o <= 1'b0;
    addr_o <= a;
    dq_o <= d; // callers keep unused bits zero
    dq_en_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    ce_n_o <= 1'b1;
    we_n_o <= 1'b1;
    repeat (2) @(posedge clock_i);
    dq_en_o <= 1'b0;
    // commit and counter load need a few edges after release
    repeat (6) @(posedge clock_i);
  endtask
  // open a read and wait, bounded, for the device to drive
  task automatic rd_begin(input logic [rtcu_pkg::ADDR_W-1:0] a, output logic ok);
    ok = 1'b0;
    @(posedge clock_i);
    ce_n_o <= 1'b0;
    oe_n_o <= 1'b0;
    we_n_o <= 1'b1;
    addr_o <= a;
    for (int i = 0; i < 8 && !ok; i++)
    begin
      @(posedge clock_i);
      #1;
      ok = (dq_oe_i === 1'b1);
    end
  endtask
  // close a read and let the drive fall away
  task automatic rd_end();
    @(posedge clock_i);
    ce_n_o <= 1'b1;
    oe_n_o <= 1'b1;
    repeat (5) @(posedge clock_i);
    #1;
  endtask
endmodule // rtcu_host_model

// ---- verif/rtc_register_update_control_tb.sv ----
// self-checking testbench for the clock register update control
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module rtc_register_update_control_tb;
  localparam int HC = 4; // short toggle period keeps a second at 4096 cycles
  localparam int SEC_CYC = 1024 * HC;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_n, oe_n, we_n, hst_en, dut_oe;
  logic [rtcu_pkg::ADDR_W-1:0] addr;
  logic [7:0] hst_dq, dut_dq;
  logic [7:0] bus_last = 8'h00; // last value seen on the pins
  wire logic [7:0] dq_bus;
  int err_count = 0;
  int n_compared = 0;
  // released pins show a changing pattern, never a stale value
  assign dq_bus = hst_en ? hst_dq : (dut_oe ? dut_dq : ~bus_last);
  always @(posedge clock_i) bus_last <= dq_bus;
  // 100 MHz clock
  always #5 clock_i = ~clock_i;
  rtcu_top #(.HALF_CYCLES(HC)) DUT (.clock_i(clock_i), .rst_i(rst_i), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr), .dq_i(dq_bus), .dq_o(dut_dq),
    .dq_oe_o(dut_oe));
  rtcu_host_model host (.clock_i(clock_i), .dq_oe_i(dut_oe), .dq_i(dq_bus), .ce_n_o(ce_n),
    .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr), .dq_o(hst_dq), .dq_en_o(hst_en));
  // address of one of the eight top clock registers
  function automatic logic [rtcu_pkg::ADDR_W-1:0] top(input logic [2:0] idx);
    return {rtcu_pkg::TOP_PAGE, idx};
  endfunction
  // full read; pins must float again once deselected
  task automatic rd(input logic [2:0] idx, output logic [7:0] d);
    logic ok;
    host.rd_begin(top(idx), ok);
    @(posedge clock_i);
    #1;
    d = dq_bus;
    host.rd_end();
    `CHK(ok, 1'b1)
    `CHK(dut_oe, 1'b0)
  endtask
  task automatic t_reset();
    logic [7:0] d;
    rd(rtcu_pkg::IDX_CENT, d);
    `CHK(d, 8'h00)
    rd(rtcu_pkg::IDX_DAY, d);
    `CHK(d, 8'h81)
    rd(rtcu_pkg::IDX_MONTH, d);
    `CHK(d, 8'h01)
  endtask
  // load a new time under write-hold, then release with a new century
  task automatic t_set_clock();
    logic [7:0] d;
    host.wr(top(rtcu_pkg::IDX_CENT), 8'h80);
    host.wr(top(rtcu_pkg::IDX_SEC), 8'h30);
    host.wr(top(rtcu_pkg::IDX_MIN), 8'h15);
    host.wr(top(rtcu_pkg::IDX_HOUR), 8'h23);
    repeat (SEC_CYC + 200) @(posedge clock_i);
    rd(rtcu_pkg::IDX_SEC, d);
    `CHK(d, 8'h30)
    host.wr(top(rtcu_pkg::IDX_CENT), 8'h20);
    rd(rtcu_pkg::IDX_CENT, d);
    `CHK(d, 8'h20)
    rd(rtcu_pkg::IDX_SEC, d);
    `CHK(d, 8'h30)
    rd(rtcu_pkg::IDX_HOUR, d);
    `CHK(d, 8'h23)
  endtask
  // freeze for a snapshot, then release and expect the lost time back
  task automatic t_read_hold();
    logic [7:0] c, s0, s1;
    host.wr(top(rtcu_pkg::IDX_CENT), 8'h45);
    rd(rtcu_pkg::IDX_CENT, c);
    `CHK(c, 8'h60)
    rd(rtcu_pkg::IDX_SEC, s0);
    `CHK(s0, 8'h30)
    repeat (2 * SEC_CYC) @(posedge clock_i);
    rd(rtcu_pkg::IDX_SEC, s1);
    `CHK(s1, s0)
    host.wr(top(rtcu_pkg::IDX_CENT), 8'h00);
    rd(rtcu_pkg::IDX_CENT, c);
    `CHK(c, 8'h20)
    repeat (100) @(posedge clock_i);
    rd(rtcu_pkg::IDX_SEC, s1);
    `CHK(s1 == s0 + 8'h02 || s1 == s0 + 8'h03, 1'b1)
    // stay released well past the minimum before any new freeze
    repeat (SEC_CYC / 4) @(posedge clock_i);
  endtask
  task automatic t_bcd_carry();
    logic [7:0] d;
    host.wr(top(rtcu_pkg::IDX_MIN), 8'h09);
    host.wr(top(rtcu_pkg::IDX_SEC), 8'h59);
    repeat (SEC_CYC + 100) @(posedge clock_i);
    rd(rtcu_pkg::IDX_MIN, d);
    `CHK(d, 8'h10)
  endtask
  task automatic t_osc_halt();
    logic [7:0] d;
    host.wr(top(rtcu_pkg::IDX_SEC), 8'h80);
    repeat (2 * SEC_CYC) @(posedge clock_i);
    rd(rtcu_pkg::IDX_SEC, d);
    `CHK(d, 8'h80)
    host.wr(top(rtcu_pkg::IDX_SEC), 8'h00);
  endtask
  // sustained seconds read: bit 0 toggles every HC cycles
  task automatic t_freq_test();
    logic ok, prev;
    logic [7:0] d;
    int flips;
    flips = 0;
    host.wr(top(rtcu_pkg::IDX_DAY), 8'h41);
    host.rd_begin(top(rtcu_pkg::IDX_SEC), ok);
    prev = dq_bus[0];
    for (int i = 0; i < 16 * HC; i++)
    begin
      @(posedge clock_i);
      #1;
      if (dq_bus[0] !== prev) flips++;
      prev = dq_bus[0];
    end
    host.rd_end();
    `CHK(flips >= 15 && flips <= 17, 1'b1)
    `CHK(ok, 1'b1)
    host.wr(top(rtcu_pkg::IDX_DAY), 8'h01);
    rd(rtcu_pkg::IDX_DAY, d);
    `CHK(d, 8'h81)
  endtask
  // below the top page nothing is driven and nothing changes
  task automatic t_off_page();
    logic ok;
    logic [7:0] d;
    host.rd_begin(19'h7fff0, ok);
    host.rd_end();
    `CHK(ok, 1'b0)
    host.wr(19'h7fff0, 8'h80);
    rd(rtcu_pkg::IDX_CENT, d);
    `CHK(d, 8'h20)
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    t_reset();
    t_set_clock();
    t_read_hold();
    t_bcd_carry();
    t_osc_halt();
    t_freq_test();
    t_off_page();
    give_verdict();
  end
  // watchdog: the sequence needs roughly 26k cycles
  initial
  begin
    repeat (90000) @(posedge clock_i);
    err_count++;
    give_verdict();
  end
endmodule // rtc_register_update_control_tb
